/* File: dsr_ctrl_model.sv */
`timescale 1ns/10ps
module dsr_ctrl_model (
   input wire logic sr_req,
   input wire logic dev_rst_n,
   input wire dsr_pkg::dsr_cmd_t cmd_in,
   input wire logic odt_in,
   output dsr_pkg::dsr_pins_t pins
);
   import dsr_pkg::*;
   logic ck = 1'b0;
   logic cke = 1'b1;
   logic odt = 1'b0;
   dsr_cmd_t cmd = 4'hf;
   int stage = 0;
   // Quiet clocks after exit; covers a floating write reference as well.
   localparam int REF_VALID_CK = 512;
   int hold = 0;
   assign pins = '{ck, cke, odt, dev_rst_n, cmd};
   // The clock never stops, so exit needs no extra clock window.
   always
   begin
      #62.5 ck = ~ck;
      if (!ck)
      begin
         if (sr_req && stage == 0)
         begin
            odt = 1'b0;
            cmd = 4'h7;
            stage = 1;
         end
         else if (sr_req && stage == 1)
         begin
            cke = 1'b0;
            cmd = CMD_REFRESH;
            stage = 2;
         end
         else if (sr_req && stage == 2)
         begin
            cmd = 4'h7;
            stage = 3;
         end
         else if (sr_req)
         begin
            // Inputs are don't care now; toggling exposes any leak.
            cmd = ~cmd;
            odt = ~odt;
         end
         else if (stage != 0)
         begin
            cke = 1'b1;
            cmd = 4'h7;
            odt = 1'b0;
            hold = REF_VALID_CK;
            stage = 0;
         end
         else if (hold != 0)
         begin
            cmd = 4'h7;
            odt = 1'b0;
            hold--;
         end
         else
         begin
            cmd = cmd_in;
            odt = odt_in;
         end
      end
   end
endmodule

/* File: dsr_pkg.sv */
package dsr_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_REF_INTERVAL = 8'h04;
   localparam logic [7:0] REG_XS_CYCLES = 8'h08;
   localparam logic [7:0] REG_XSDLL_CYCLES = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Control bit positions.
   localparam int CTRL_TEMP_OPT = 0;
   localparam int CTRL_AUTO_RATE = 1;
   // Status bit positions.
   localparam int ST_DLL_EN = 2;
   localparam int ST_DLL_LOCKED = 3;
   localparam int ST_SR_ACTIVE = 4;
   localparam int ST_REF_BUSY = 5;
   localparam int ST_ENTRY_LO = 8;
   localparam int ST_ENTRY_HI = 15;
   // Clock rate and timing figures.
   localparam int CLK_MHZ = 100;
   localparam int TREFI_NS = 7800;
   localparam logic [15:0] REF_INTERVAL_RST =
      16'(TREFI_NS * CLK_MHZ / 1000);
   localparam int TRFC_NS = 110;
   localparam logic [7:0] TRFC_CYC =
      8'((TRFC_NS * CLK_MHZ + 999) / 1000);
   localparam logic [9:0] XS_CYCLES_RST = 10'h010;
   localparam logic [9:0] XSDLL_CYCLES_RST = 10'h200;
   localparam logic [1:0] CTRL_RST = 2'h0;
   // Pin command code for REFRESH: cs_n, ras_n, cas_n, we_n.
   localparam logic [3:0] CMD_REFRESH = 4'h1;

   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } dsr_cmd_t;

   typedef struct packed {
      logic ck;
      logic cke;
      logic odt;
      logic reset_n;
      dsr_cmd_t cmd;
   } dsr_pins_t;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_SELFREF,
      ST_EXIT_ARM,
      ST_XS_WAIT
   } dsr_state_t;
endpackage

/* File: dsr_sync.sv */
`timescale 1ns/10ps
module dsr_sync #(
   parameter int W = 8
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);
   logic [W-1:0] meta_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= '0;
         dout <= '0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule

/* File: dsr_top.sv */
`timescale 1ns/10ps
module dsr_top (
   input wire logic aclk,
   input wire logic aresetn,
   input wire dsr_pkg::dsr_pins_t pins,
   input wire logic awvalid,
   output logic awready,
   input wire logic [dsr_pkg::ADDR_W-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [dsr_pkg::ADDR_W-1:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic dll_enable_q,
   output logic dll_reset_q,
   output logic dll_locked_q,
   output logic int_refresh_q,
   output logic selfref_active_q,
   output logic cmd_valid_q,
   output dsr_pkg::dsr_cmd_t cmd_q,
   output logic odt_q
);
   import dsr_pkg::*;

   dsr_pins_t pins_s;
   logic ck_d_q;
   logic ck_rise;
   logic dev_rst;
   dsr_state_t state_q;
   dsr_state_t state_d;
   logic entry_hit;
   logic [1:0] ctrl_q;
   logic [15:0] ref_interval_q;
   logic [9:0] xs_cycles_q;
   logic [9:0] xsdll_cycles_q;
   logic [15:0] ref_tmr_q;
   logic [15:0] ref_reload;
   logic [7:0] ref_busy_q;
   logic [9:0] xs_cnt_q;
   logic [9:0] xsdll_cnt_q;
   logic [7:0] entry_cnt_q;
   logic aw_full_q;
   logic w_full_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic wr_fire;
   logic wr_hit;
   logic [31:0] status_w;

   // Every pin is foreign to aclk, so all of them go through two flops.
   dsr_sync #(.W($bits(dsr_pins_t))) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(pins),
      .dout(pins_s)
   );

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         ck_d_q <= 1'b0;
      else
         ck_d_q <= pins_s.ck;
   end

   assign ck_rise = pins_s.ck & ~ck_d_q;
   // The device reset pin stays live in every state.
   assign dev_rst = ~pins_s.reset_n;
   assign entry_hit = ck_rise && !pins_s.cke &&
      (pins_s.cmd == CMD_REFRESH);
   // The zero count is a cycle of its own, so the reload is one short.
   assign ref_reload = (ctrl_q[CTRL_TEMP_OPT] ?
      (ref_interval_q >> 1) : ref_interval_q) - 16'h0001;

   always_comb
   begin
      state_d = state_q;
      unique case (state_q)
         ST_IDLE:
            if (entry_hit)
               state_d = ST_SELFREF;
         ST_SELFREF:
            // Exit does not wait for a clock edge: the clock may be stopped.
            if (pins_s.cke)
               state_d = ST_EXIT_ARM;
         ST_EXIT_ARM:
            if (!pins_s.cke)
               state_d = ST_SELFREF;
            else if (ck_rise)
               state_d = ST_XS_WAIT;
         ST_XS_WAIT:
            // A refresh still running must finish before tXS can end.
            if (xs_cnt_q == '0 && ref_busy_q == '0)
               state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || dev_rst)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || dev_rst)
      begin
         dll_enable_q <= 1'b1;
         dll_reset_q <= 1'b0;
         selfref_active_q <= 1'b0;
      end
      else
      begin
         dll_enable_q <= (state_d != ST_SELFREF);
         dll_reset_q <= (state_q == ST_SELFREF) &&
            (state_d == ST_EXIT_ARM);
         selfref_active_q <= (state_d == ST_SELFREF);
      end
   end

   // Internal refresh: one at entry, then one per interval while inside.
   // The temperature option doubles the rate for hot operation.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || dev_rst)
      begin
         int_refresh_q <= 1'b0;
         ref_tmr_q <= '0;
         ref_busy_q <= '0;
      end
      else
      begin
         int_refresh_q <= 1'b0;
         if (ref_busy_q != '0)
            ref_busy_q <= ref_busy_q - 8'h01;
         if (state_q == ST_IDLE && state_d == ST_SELFREF)
         begin
            int_refresh_q <= 1'b1;
            ref_busy_q <= TRFC_CYC;
            ref_tmr_q <= ref_reload;
         end
         else if (state_q == ST_SELFREF)
         begin
            if (ref_tmr_q == '0)
            begin
               int_refresh_q <= 1'b1;
               ref_busy_q <= TRFC_CYC;
               ref_tmr_q <= ref_reload;
            end
            else
               ref_tmr_q <= ref_tmr_q - 16'h0001;
         end
      end
   end

   // Exit timers count link clock edges from the first qualifying edge.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || dev_rst)
      begin
         xs_cnt_q <= '0;
         xsdll_cnt_q <= '0;
         dll_locked_q <= 1'b1;
      end
      else if (state_q == ST_EXIT_ARM && state_d == ST_XS_WAIT)
      begin
         xs_cnt_q <= xs_cycles_q;
         xsdll_cnt_q <= xsdll_cycles_q;
         dll_locked_q <= 1'b0;
      end
      else if (state_q == ST_SELFREF || state_q == ST_EXIT_ARM)
         dll_locked_q <= 1'b0;
      else
      begin
         if (ck_rise && xs_cnt_q != '0)
            xs_cnt_q <= xs_cnt_q - 10'h001;
         if (ck_rise && xsdll_cnt_q != '0)
            xsdll_cnt_q <= xsdll_cnt_q - 10'h001;
         dll_locked_q <= (xsdll_cnt_q == '0);
      end
   end

   // Commands reach the core only when awake and clocked with CKE high.
   always_ff @(posedge aclk)
   begin
      if (!aresetn || dev_rst)
      begin
         cmd_valid_q <= 1'b0;
         cmd_q <= '1;
         odt_q <= 1'b0;
      end
      else
      begin
         cmd_valid_q <= 1'b0;
         if (ck_rise && pins_s.cke &&
            (state_q == ST_IDLE || state_q == ST_XS_WAIT))
         begin
            cmd_valid_q <= 1'b1;
            cmd_q <= pins_s.cmd;
            odt_q <= pins_s.odt;
         end
         else if (state_q != ST_IDLE && state_q != ST_XS_WAIT)
            odt_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         entry_cnt_q <= '0;
      else if (state_q == ST_IDLE && state_d == ST_SELFREF)
         entry_cnt_q <= entry_cnt_q + 8'h01;
   end

   // AXI4-Lite slave. Address and data are caught in either order.
   assign wr_fire = aw_full_q && w_full_q && !bvalid;
   assign wr_hit = (aw_addr_q[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2]) ||
      (aw_addr_q[ADDR_W-1:2] == REG_REF_INTERVAL[ADDR_W-1:2]) ||
      (aw_addr_q[ADDR_W-1:2] == REG_XS_CYCLES[ADDR_W-1:2]) ||
      (aw_addr_q[ADDR_W-1:2] == REG_XSDLL_CYCLES[ADDR_W-1:2]);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awready <= 1'b1;
         wready <= 1'b1;
         aw_addr_q <= '0;
         w_data_q <= '0;
         w_strb_q <= '0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end
      else
      begin
         if (awvalid && awready)
         begin
            aw_full_q <= 1'b1;
            awready <= 1'b0;
            aw_addr_q <= awaddr;
         end
         if (wvalid && wready)
         begin
            w_full_q <= 1'b1;
            wready <= 1'b0;
            w_data_q <= wdata;
            w_strb_q <= wstrb;
         end
         if (wr_fire)
         begin
            bvalid <= 1'b1;
            bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid && bready)
         begin
            bvalid <= 1'b0;
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= CTRL_RST;
         ref_interval_q <= REF_INTERVAL_RST;
         xs_cycles_q <= XS_CYCLES_RST;
         xsdll_cycles_q <= XSDLL_CYCLES_RST;
      end
      else if (wr_fire)
      begin
         if (aw_addr_q[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2] && w_strb_q[0])
            ctrl_q <= w_data_q[1:0];
         if (aw_addr_q[ADDR_W-1:2] == REG_REF_INTERVAL[ADDR_W-1:2])
         begin
            if (w_strb_q[0])
               ref_interval_q[7:0] <= w_data_q[7:0];
            if (w_strb_q[1])
               ref_interval_q[15:8] <= w_data_q[15:8];
         end
         if (aw_addr_q[ADDR_W-1:2] == REG_XS_CYCLES[ADDR_W-1:2])
         begin
            if (w_strb_q[0])
               xs_cycles_q[7:0] <= w_data_q[7:0];
            if (w_strb_q[1])
               xs_cycles_q[9:8] <= w_data_q[9:8];
         end
         if (aw_addr_q[ADDR_W-1:2] == REG_XSDLL_CYCLES[ADDR_W-1:2])
         begin
            if (w_strb_q[0])
               xsdll_cycles_q[7:0] <= w_data_q[7:0];
            if (w_strb_q[1])
               xsdll_cycles_q[9:8] <= w_data_q[9:8];
         end
      end
   end

   always_comb
   begin
      status_w = '0;
      status_w[1:0] = state_q;
      status_w[ST_DLL_EN] = dll_enable_q;
      status_w[ST_DLL_LOCKED] = dll_locked_q;
      status_w[ST_SR_ACTIVE] = selfref_active_q;
      status_w[ST_REF_BUSY] = (ref_busy_q != '0);
      status_w[ST_ENTRY_HI:ST_ENTRY_LO] = entry_cnt_q;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= RESP_OKAY;
         rdata <= '0;
         if (araddr[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2])
            rdata[1:0] <= ctrl_q;
         else if (araddr[ADDR_W-1:2] == REG_REF_INTERVAL[ADDR_W-1:2])
            rdata[15:0] <= ref_interval_q;
         else if (araddr[ADDR_W-1:2] == REG_XS_CYCLES[ADDR_W-1:2])
            rdata[9:0] <= xs_cycles_q;
         else if (araddr[ADDR_W-1:2] == REG_XSDLL_CYCLES[ADDR_W-1:2])
            rdata[9:0] <= xsdll_cycles_q;
         else if (araddr[ADDR_W-1:2] == REG_STATUS[ADDR_W-1:2])
            rdata <= status_w;
         else
            rresp <= RESP_SLVERR;
      end
      else if (rvalid && rready)
      begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   chk_entry_state: assert property (@(posedge aclk)
      disable iff (!aresetn || dev_rst)
      (state_q == ST_IDLE && entry_hit) |=> selfref_active_q)
      else $error("Entry command did not start self refresh.");

   chk_dll_off: assert property (@(posedge aclk)
      disable iff (!aresetn || dev_rst)
      (state_q == ST_SELFREF && $past(state_q) == ST_SELFREF)
         |-> !dll_enable_q)
      else $error("DLL left on during self refresh.");

   chk_dll_reset: assert property (@(posedge aclk)
      disable iff (!aresetn || dev_rst)
      (state_q == ST_SELFREF ##1 state_q == ST_EXIT_ARM)
         |-> dll_enable_q && dll_reset_q ##1 !dll_reset_q)
      else $error("DLL not re-enabled and reset on exit.");

   chk_ignore_cmd: assert property (@(posedge aclk)
      disable iff (!aresetn || dev_rst)
      (state_q == ST_SELFREF)[*2] |=> !cmd_valid_q)
      else $error("Command passed while in self refresh.");

   chk_entry_refresh: assert property (@(posedge aclk)
      disable iff (!aresetn || dev_rst)
      $rose(selfref_active_q) |-> int_refresh_q)
      else $error("No internal refresh at entry.");

   chk_xs_start: assert property (@(posedge aclk)
      disable iff (!aresetn || dev_rst)
      (state_q == ST_EXIT_ARM && pins_s.cke && ck_rise)
         |=> xs_cnt_q == $past(xs_cycles_q) &&
         xsdll_cnt_q == $past(xsdll_cycles_q) && !dll_locked_q)
      else $error("Exit timers not started at first edge.");
endmodule

/* File: tb.sv */
`timescale 1ns/10ps
module tb;
   import dsr_pkg::*;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [31:0] data;
      logic [1:0] resp;
   } dsr_row_t;
   localparam logic [31:0] ST_RST = 32'h0c;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic sr_req = 1'b0, dev_rst_n = 1'b1, odt_in = 1'b0;
   dsr_cmd_t cmd_in = 4'h7;
   dsr_pins_t pins;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rsp;
   logic [31:0] rdata, rd;
   logic dll_enable_q, dll_reset_q, dll_locked_q, int_refresh_q;
   logic selfref_active_q, cmd_valid_q, odt_q;
   dsr_cmd_t cmd_q;
   int n_errors = 0, n_compared = 0, n_cyc = 0, n_ref = 0, n_leak = 0;
   int i, t;
   dsr_row_t rows [0:12] = '{
      '{1'b0, REG_CTRL, 32'(CTRL_RST), RESP_OKAY},
      '{1'b0, REG_REF_INTERVAL, 32'(REF_INTERVAL_RST), RESP_OKAY},
      '{1'b0, REG_XS_CYCLES, 32'(XS_CYCLES_RST), RESP_OKAY},
      '{1'b0, REG_XSDLL_CYCLES, 32'(XSDLL_CYCLES_RST), RESP_OKAY},
      '{1'b0, REG_STATUS, ST_RST, RESP_OKAY},
      '{1'b0, 8'h14, 32'h0, RESP_SLVERR},
      '{1'b1, REG_STATUS, 32'h0, RESP_SLVERR},
      '{1'b1, 8'h40, 32'h1, RESP_SLVERR},
      '{1'b1, REG_REF_INTERVAL, 32'h14, RESP_OKAY},
      '{1'b1, REG_XS_CYCLES, 32'h2, RESP_OKAY},
      '{1'b1, REG_XSDLL_CYCLES, 32'h4, RESP_OKAY},
      '{1'b0, REG_REF_INTERVAL, 32'h14, RESP_OKAY},
      '{1'b0, REG_XSDLL_CYCLES, 32'h4, RESP_OKAY}};

   dsr_ctrl_model partner (.sr_req(sr_req), .dev_rst_n(dev_rst_n),
      .cmd_in(cmd_in), .odt_in(odt_in), .pins(pins));
   dsr_top dut (.aclk(aclk), .aresetn(aresetn), .pins(pins),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
      .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr),
      .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
      .rresp(rresp), .dll_enable_q(dll_enable_q),
      .dll_reset_q(dll_reset_q), .dll_locked_q(dll_locked_q),
      .int_refresh_q(int_refresh_q), .selfref_active_q(selfref_active_q),
      .cmd_valid_q(cmd_valid_q), .cmd_q(cmd_q), .odt_q(odt_q));

   initial
   begin
      forever #5 aclk = ~aclk;
   end

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      n_compared++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
         if (bvalid && bready)
         begin
            r = bresp;
            bready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      logic done;
      done = 1'b0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (!done)
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
         if (rvalid && rready)
         begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            done = 1'b1;
         end
      end
   endtask

   // The ceiling is several times the expected run, so only a hang hits it.
   always @(posedge aclk)
   begin
      n_cyc++;
      if (int_refresh_q === 1'b1)
         n_ref++;
      if (selfref_active_q === 1'b1 && (cmd_valid_q !== 1'b0 || odt_q !== 1'b0))
         n_leak++;
      if (n_cyc == 20000)
      begin
         n_errors++;
         complete_run();
      end
   end

   initial
   begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 13; i++)
      begin
         if (rows[i].wr)
            axi_write(rows[i].addr, rows[i].data, rsp);
         else
            axi_read(rows[i].addr, rd, rsp);
         if (!rows[i].wr)
            cmp("rdata", rows[i].data, rd);
         cmp("resp", 32'(rows[i].resp), 32'(rsp));
      end
      $display("test registers done");
      odt_in <= 1'b1;
      cmd_in <= 4'h5;
      repeat (40) @(posedge aclk);
      for (t = 0; t < 60 && cmd_valid_q !== 1'b1; t++) @(posedge aclk);
      cmp("cmd_valid_q", 32'h1, 32'(cmd_valid_q));
      cmp("cmd_q", 32'h5, 32'(cmd_q));
      cmp("odt_q", 32'h1, 32'(odt_q));
      odt_in <= 1'b0;
      cmd_in <= CMD_REFRESH;
      repeat (60) @(posedge aclk);
      cmp("active on refresh", 32'h0, 32'(selfref_active_q));
      cmd_in <= 4'h7;
      $display("test forwarding done");
      sr_req <= 1'b1;
      for (t = 0; t < 200 && selfref_active_q !== 1'b1; t++) @(posedge aclk);
      cmp("active", 32'h1, 32'(selfref_active_q));
      cmp("first refresh", 32'h1, 32'(int_refresh_q));
      cmp("dll_enable_q", 32'h0, 32'(dll_enable_q));
      // Counting between falling edges keeps the window clear of the pulses.
      @(negedge aclk);
      n_ref = 0;
      repeat (200) @(negedge aclk);
      cmp("refresh count", 32'ha, 32'(n_ref));
      cmp("dll_locked_q", 32'h0, 32'(dll_locked_q));
      axi_read(REG_STATUS, rd, rsp);
      cmp("status in self refresh", 32'h0111, rd & 32'hffdf);
      axi_write(REG_CTRL, 32'h3, rsp);
      // Let the old interval run out before counting at the doubled rate.
      repeat (20) @(negedge aclk);
      n_ref = 0;
      repeat (200) @(negedge aclk);
      cmp("fast refresh count", 32'h14, 32'(n_ref));
      axi_read(REG_CTRL, rd, rsp);
      cmp("ctrl", 32'h3, rd);
      axi_write(REG_CTRL, 32'h0, rsp);
      cmp("ignored inputs", 32'h0, 32'(n_leak));
      $display("test entry done");
      sr_req <= 1'b0;
      for (t = 0; t < 200 && dll_reset_q !== 1'b1; t++) @(posedge aclk);
      cmp("dll_reset_q", 32'h1, 32'(dll_reset_q));
      cmp("dll_enable_q", 32'h1, 32'(dll_enable_q));
      cmp("active", 32'h0, 32'(selfref_active_q));
      for (t = 0; t < 400 && dll_locked_q !== 1'b1; t++) @(posedge aclk);
      // Four clock edges of 12.5 cycles each, plus sync and edge lag.
      cmp("lock wait", 32'h1, 32'(t >= 36 && t <= 100));
      axi_read(REG_STATUS, rd, rsp);
      cmp("state", 32'h0, rd & 32'h3);
      $display("test exit done");
      sr_req <= 1'b1;
      for (t = 0; t < 200 && selfref_active_q !== 1'b1; t++) @(posedge aclk);
      dev_rst_n <= 1'b0;
      for (t = 0; t < 10 && selfref_active_q !== 1'b0; t++) @(posedge aclk);
      cmp("active after pin reset", 32'h0, 32'(selfref_active_q));
      sr_req <= 1'b0;
      dev_rst_n <= 1'b1;
      repeat (50) @(posedge aclk);
      cmp("dll_enable_q", 32'h1, 32'(dll_enable_q));
      $display("test pin reset done");
      aresetn <= 1'b0;
      repeat (4) @(posedge aclk);
      cmp("ready", 32'h7, {29'h0, awready, wready, arready});
      cmp("bvalid", 32'h0, 32'(bvalid));
      cmp("cmd_q", 32'hf, 32'(cmd_q));
      aresetn <= 1'b1;
      axi_read(REG_REF_INTERVAL, rd, rsp);
      cmp("interval", 32'(REF_INTERVAL_RST), rd);
      axi_read(REG_STATUS, rd, rsp);
      cmp("status", ST_RST, rd);
      $display("test reset done");
      complete_run();
   end
endmodule
